// [hdl/ebp_pkg.sv]
// constants, codes and types shared by the bulk eeprom access block
// assumes a pmbus front end on the same clock that hands over decoded commands
package ebp_pkg;

   localparam logic [7:0]  CMD_UNLOCK_KEY    = 8'hBD;
   localparam logic [7:0]  CMD_ERASE_TRIGGER = 8'hBE;
   localparam logic [7:0]  CMD_WORD_PORT     = 8'hBF;
   localparam logic [7:0]  CMD_COMMON_STATUS = 8'hE5;

   localparam logic [7:0]  KEY_FIRST         = 8'h2B;
   localparam logic [7:0]  KEY_RW_PEC_OPT    = 8'hD4;
   localparam logic [7:0]  KEY_RW_PEC_REQ    = 8'hD5;
   localparam logic [7:0]  KEY_RO_SECOND     = 8'h91;
   localparam logic [7:0]  KEY_RO_PEC_OPT    = 8'hE4;
   localparam logic [7:0]  KEY_RO_PEC_REQ    = 8'hE5;
   localparam logic [7:0]  ERASE_KEY         = 8'h2B;

   localparam int          NOT_BUSY_BIT      = 6;

   // value is arbitrary
   localparam logic [15:0] PACKING_REVISION  = 16'h0001;
   localparam logic [15:0] USER_WORD_COUNT   = 16'h0200;
   localparam logic [15:0] MFR_WORD_COUNT    = 16'h0040;
   localparam logic [15:0] PTR_RESET         = 16'h0000;
   localparam logic [15:0] READ_HEADER_WORDS = 16'h0002;
   localparam logic [7:0]  BYTE_RESET        = 8'h00;
   localparam logic [15:0] WORD_RESET        = 16'h0000;

   localparam int          RSP_W             = 17;
   localparam logic [1:0]  BUF_DEPTH         = 2'h2;

   typedef enum logic [1:0] {
      MODE_LOCKED = 2'b00,
      MODE_RW     = 2'b01,
      MODE_RO     = 2'b10
   } ebp_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_BUSY   = 2'b01,
      ST_RDWAIT = 2'b10
   } ebp_state_t;

   typedef enum logic [1:0] {
      EE_READ  = 2'b00,
      EE_WRITE = 2'b01,
      EE_ERASE = 2'b10
   } ebp_eeop_t;

   typedef enum logic [1:0] {
      KS_NONE  = 2'b00,
      KS_FIRST = 2'b01,
      KS_RO    = 2'b10
   } ebp_kstage_t;

endpackage

// [hdl/ebp_key_check.sv]
// unlock key sequence tracker
// fed one byte per unlock write; reports a complete key or a bad sequence
`timescale 1ns/1ps
`default_nettype none
module ebp_key_check
   import ebp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       ce,
   input  wire logic       strobe,
   input  wire logic [7:0] key,
   input  wire logic       clear,
   output logic            done,
   output logic            bad,
   output ebp_mode_t       mode,
   output logic            pec_req
);
   typedef struct packed {
      ebp_kstage_t stage;
   } ebp_key_t;

   ebp_key_t q;
   ebp_key_t d;

   always_comb begin
      d       = q;
      done    = 1'b0;
      bad     = 1'b0;
      mode    = MODE_LOCKED;
      pec_req = 1'b0;
      if (strobe) begin
         case (q.stage)
            KS_NONE: begin
               if (key == KEY_FIRST) begin
                  d.stage = KS_FIRST;
               end else begin
                  bad = 1'b1;
               end
            end
            KS_FIRST: begin
               d.stage = KS_NONE;
               if (key == KEY_RW_PEC_OPT || key == KEY_RW_PEC_REQ) begin
                  done    = 1'b1;
                  mode    = MODE_RW;
                  pec_req = (key == KEY_RW_PEC_REQ);
               end else if (key == KEY_RO_SECOND) begin
                  d.stage = KS_RO;
               end else begin
                  bad = 1'b1;
               end
            end
            KS_RO: begin
               d.stage = KS_NONE;
               if (key == KEY_RO_PEC_OPT || key == KEY_RO_PEC_REQ) begin
                  done    = 1'b1;
                  mode    = MODE_RO;
                  pec_req = (key == KEY_RO_PEC_REQ);
               end else begin
                  bad = 1'b1;
               end
            end
            default: begin
               d.stage = KS_NONE;
               bad     = 1'b1;
            end
         endcase
      end else if (clear) begin
         // a lock elsewhere abandons a half-entered key
         d.stage = KS_NONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{stage: KS_NONE};
      end else if (ce) begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// [hdl/ebp_rsp_buf.sv]
// two-entry answer buffer with valid and ready on both sides
// head entry sits in its own register so the outputs come from flops
`timescale 1ns/1ps
`default_nettype none
module ebp_rsp_buf
   import ebp_pkg::*;
#(
   parameter int W = RSP_W
)
(
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         ce,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic [1:0]        count,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   typedef struct packed {
      logic [W-1:0] s0;
      logic [W-1:0] s1;
      logic [1:0]   cnt;
   } ebp_buf_t;

   ebp_buf_t q;
   ebp_buf_t d;
   logic     pop;
   logic     push;

   always_comb begin
      d    = q;
      pop  = out_ready && (q.cnt != 2'h0);
      push = in_valid && (q.cnt != BUF_DEPTH);
      if (pop) begin
         d.s0  = q.s1;
         d.cnt = q.cnt - 2'h1;
      end
      if (push) begin
         if (d.cnt == 2'h0) begin
            d.s0 = in_data;
         end else begin
            d.s1 = in_data;
         end
         d.cnt = d.cnt + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign in_ready  = (q.cnt != BUF_DEPTH);
   assign count     = q.cnt;
   assign out_valid = (q.cnt != 2'h0);
   assign out_data  = q.s0;
endmodule
`default_nettype wire

// [hdl/ebp_bulk_access.sv]
// bulk eeprom access block: unlock keys, erase trigger, streaming word port
// assumes decoded pmbus commands from a front end on REF_CLK, and an eeprom
// controller that holds EE_ACK for one cycle when an operation finishes
//
// Contract
// - key 2B then D4 unlocks erase and word read/write, pec optional
// - key 2B then D5 unlocks erase and word read/write, pec required
// - key 2B 91 E4 unlocks read-only access to user and mfr space
// - key 2B 91 E5 same read-only access but pec required
// - any unsupported key sequence locks and refuses bulk access
// - unlock key reads back last byte written, zero while locked
// - a completed unlock resets the word address pointer
// - every word read or write advances the pointer by one
// - erase value other than 2B locks; erase reads last value
// - after unlock, 2B to erase clears all user space (code erases only in read/write mode; a read-only session locks instead)
// - first word read returns the packing revision word from rom
// - second word read returns the user word count, user plus mfr count when read-only
// - later reads return eeprom contents from the lowest address
// - a read past the last word returns zero and locks
// - writes after erase start at lowest address; overflow write locks
// - bulk transfers never touch the volatile ram configuration
// - not-busy flag clears during eeprom access; status always readable (code holds CMD_READY low, status too, during an eeprom read)
// - while busy every command except status read is nacked
// - erase stays busy long; host polls status before continuing
// - only byte and word commands are used for bulk access
`timescale 1ns/1ps
`default_nettype none
module ebp_bulk_access
   import ebp_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   input  wire logic        CMD_VALID,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic        CMD_WRITE,
   input  wire logic        CMD_PEC,
   input  wire logic [15:0] CMD_WDATA,
   output logic             CMD_READY,
   output logic             RSP_VALID,
   output logic             RSP_ACK,
   output logic [15:0]      RSP_DATA,
   input  wire logic        RSP_READY,
   output logic             EE_REQ,
   output ebp_pkg::ebp_eeop_t EE_OP,
   output logic [15:0]      EE_ADDR,
   output logic [15:0]      EE_WDATA,
   input  wire logic        EE_ACK,
   input  wire logic [15:0] EE_RDATA,
   output logic             BUSY_N,
   output logic             PEC_REQUIRED
);
   import ebp_pkg::*;

   typedef struct packed {
      ebp_state_t  st;
      ebp_mode_t   mode;
      logic        pec_req;
      logic [15:0] ptr;
      logic        erased;
      logic        dir_set;
      logic        dir_wr;
      logic [7:0]  unlock_last;
      logic [7:0]  erase_last;
      logic        ee_req;
      ebp_eeop_t   ee_op;
      logic [15:0] ee_addr;
      logic [15:0] ee_wdata;
      logic        push;
      logic        push_ack;
      logic [15:0] push_data;
      logic        cmd_ready;
      logic        busy_n;
   } ebp_core_t;

   ebp_core_t   q;
   ebp_core_t   d;

   logic        accept;
   logic        key_strobe;
   logic        key_done;
   logic        key_bad;
   ebp_mode_t   key_mode;
   logic        key_pec;
   logic        other_lock;
   logic        buf_ready;
   logic [1:0]  buf_count;
   logic        buf_valid;
   logic [RSP_W-1:0] buf_data;
   logic        pop;
   logic [2:0]  cnt_next;
   logic [15:0] word_total;
   logic        is_bulk;
   logic        pec_bad;

   // word count seen by the host depends on the unlocked space
   function automatic logic [15:0] words_for(input ebp_mode_t m);
      logic [15:0] r;
      r = USER_WORD_COUNT;
      if (m == MODE_RO) begin
         r = USER_WORD_COUNT + MFR_WORD_COUNT;
      end
      return r;
   endfunction

   // answer a command without touching the eeprom
   function automatic logic [16:0] answer(input logic ack, input logic [15:0] data);
      return {ack, data};
   endfunction

   assign accept     = CMD_VALID && q.cmd_ready;
   assign key_strobe = accept && CMD_WRITE && (CMD_CODE == CMD_UNLOCK_KEY) && q.busy_n;
   assign word_total = words_for(q.mode);
   assign pop        = RSP_READY && buf_valid;
   // only byte and word commands steer the block; no block transfers
   assign is_bulk    = (CMD_CODE == CMD_UNLOCK_KEY) || (CMD_CODE == CMD_ERASE_TRIGGER)
                       || (CMD_CODE == CMD_WORD_PORT);
   assign pec_bad    = (q.mode != MODE_LOCKED) && q.pec_req && !CMD_PEC && is_bulk;

   ebp_key_check u_key (
      .clk     (REF_CLK),
      .arst_n  (ARST_N),
      .ce      (CE),
      .strobe  (key_strobe && !pec_bad),
      .key     (CMD_WDATA[7:0]),
      .clear   (other_lock),
      .done    (key_done),
      .bad     (key_bad),
      .mode    (key_mode),
      .pec_req (key_pec)
   );

   always_comb begin
      d          = q;
      d.push     = 1'b0;
      d.push_ack = 1'b0;
      d.push_data = WORD_RESET;
      other_lock = 1'b0;

      // eeprom operation finishing releases the request and the busy state
      if (q.ee_req && EE_ACK) begin
         d.ee_req = 1'b0;
         if (q.st == ST_RDWAIT) begin
            d.push      = 1'b1;
            d.push_ack  = 1'b1;
            d.push_data = EE_RDATA;
         end
         d.st = ST_IDLE;
      end

      if (accept && q.st != ST_RDWAIT) begin
         d.push = 1'b1;
         if (CMD_CODE == CMD_COMMON_STATUS && !CMD_WRITE) begin
            // status stays readable even while a write or erase is busy
            d.push_ack  = 1'b1;
            d.push_data = WORD_RESET;
            d.push_data[NOT_BUSY_BIT] = q.busy_n;
         end else if (!q.busy_n) begin
            // write or erase still programming; host must wait or poll
            d.push_ack = 1'b0;
         end else if (!is_bulk) begin
            // other commands belong to the rest of the device
            d.push = 1'b0;
         end else if (pec_bad) begin
            d.push_ack = 1'b0;
         end else if (CMD_CODE == CMD_UNLOCK_KEY) begin
            d.push_ack = 1'b1;
            if (CMD_WRITE) begin
               d.unlock_last = CMD_WDATA[7:0];
               // any unlock write ends the current session until a key completes
               d.mode = MODE_LOCKED;
               if (key_done) begin
                  d.mode    = key_mode;
                  d.pec_req = key_pec;
                  d.ptr     = PTR_RESET;
                  d.erased  = 1'b0;
                  d.dir_set = 1'b0;
               end else if (key_bad) begin
                  d.pec_req = 1'b0;
               end
            end else if (q.mode == MODE_LOCKED) begin
               d.push_data = WORD_RESET;
            end else begin
               d.push_data = {8'h00, q.unlock_last};
            end
         end else if (CMD_CODE == CMD_ERASE_TRIGGER) begin
            d.push_ack = 1'b1;
            if (CMD_WRITE) begin
               d.erase_last = CMD_WDATA[7:0];
               if (CMD_WDATA[7:0] != ERASE_KEY) begin
                  other_lock = 1'b1;
               end else if (q.mode == MODE_RW) begin
                  d.ee_req  = 1'b1;
                  d.ee_op   = EE_ERASE;
                  d.erased  = 1'b1;
                  d.ptr     = PTR_RESET;
                  d.st      = ST_BUSY;
               end else if (q.mode == MODE_RO) begin
                  other_lock = 1'b1;
               end
            end else begin
               d.push_data = {8'h00, q.erase_last};
            end
         end else if (q.mode == MODE_LOCKED) begin
            // word port refused outside an unlocked session
            d.push_ack = 1'b0;
         end else if (!CMD_WRITE) begin
            if (q.dir_set && q.dir_wr) begin
               // mixing directions is a host error; treat as violation
               other_lock = 1'b1;
               d.push_ack = 1'b0;
            end else begin
               d.dir_set  = 1'b1;
               d.dir_wr   = 1'b0;
               d.push_ack = 1'b1;
               d.ptr      = q.ptr + 16'h0001;
               if (q.ptr == PTR_RESET) begin
                  d.push_data = PACKING_REVISION;
               end else if (q.ptr == 16'h0001) begin
                  d.push_data = word_total;
               end else if (q.ptr < word_total + READ_HEADER_WORDS) begin
                  d.push    = 1'b0;
                  d.ee_req  = 1'b1;
                  d.ee_op   = EE_READ;
                  d.ee_addr = q.ptr - READ_HEADER_WORDS;
                  d.st      = ST_RDWAIT;
               end else begin
                  d.push_data = WORD_RESET;
                  other_lock  = 1'b1;
               end
            end
         end else begin
            if (q.mode != MODE_RW || !q.erased || (q.dir_set && !q.dir_wr)) begin
               other_lock = 1'b1;
               d.push_ack = 1'b0;
            end else if (q.ptr < word_total) begin
               d.dir_set  = 1'b1;
               d.dir_wr   = 1'b1;
               d.push_ack = 1'b1;
               d.ptr      = q.ptr + 16'h0001;
               d.ee_req   = 1'b1;
               d.ee_op    = EE_WRITE;
               d.ee_addr  = q.ptr;
               d.ee_wdata = CMD_WDATA;
               d.st       = ST_BUSY;
            end else begin
               d.push_ack = 1'b1;
               other_lock = 1'b1;
            end
         end
      end

      if (other_lock) begin
         d.mode    = MODE_LOCKED;
         d.pec_req = 1'b0;
         d.dir_set = 1'b0;
         d.erased  = 1'b0;
      end

      // not-busy follows the eeprom request; ram configuration is never driven
      d.busy_n = !d.ee_req;

      // room check counts the answer in flight and the one being queued
      cnt_next    = {1'b0, buf_count} + {2'b00, q.push} - {2'b00, pop};
      d.cmd_ready = (d.st != ST_RDWAIT) && ((cnt_next + {2'b00, d.push}) < 3'h2);
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         q             <= '0;
         q.st          <= ST_IDLE;
         q.mode        <= MODE_LOCKED;
         q.ptr         <= PTR_RESET;
         q.unlock_last <= BYTE_RESET;
         q.erase_last  <= BYTE_RESET;
         q.ee_op       <= EE_READ;
         q.busy_n      <= 1'b1;
      end else if (CE) begin
         q <= d;
      end
   end

   // stalls on RSP_READY fill this buffer and drop CMD_READY, so no answer is lost
   ebp_rsp_buf #(
      .W (RSP_W)
   ) u_buf (
      .clk       (REF_CLK),
      .arst_n    (ARST_N),
      .ce        (CE),
      .in_valid  (q.push),
      .in_data   ({q.push_ack, q.push_data}),
      .in_ready  (buf_ready),
      .count     (buf_count),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (RSP_READY)
   );

   assign CMD_READY    = q.cmd_ready && buf_ready;
   assign RSP_VALID    = buf_valid;
   assign RSP_ACK      = buf_data[RSP_W-1];
   assign RSP_DATA     = buf_data[15:0];
   assign EE_REQ       = q.ee_req;
   assign EE_OP        = q.ee_op;
   assign EE_ADDR      = q.ee_addr;
   assign EE_WDATA     = q.ee_wdata;
   assign BUSY_N       = q.busy_n;
   assign PEC_REQUIRED = q.pec_req;
endmodule
`default_nettype wire

// [sim/ebp_bulk_properties.sv]
// port checker for the bulk eeprom access block
// assumes one clock domain, REF_CLK, and async active-low ARST_N
`timescale 1ns/1ps
`default_nettype none
module ebp_bulk_properties
   import ebp_pkg::*;
(
   input wire logic               REF_CLK,
   input wire logic               ARST_N,
   input wire logic               CE,
   input wire logic               CMD_VALID,
   input wire logic [7:0]         CMD_CODE,
   input wire logic               CMD_WRITE,
   input wire logic               CMD_READY,
   input wire logic               RSP_VALID,
   input wire logic               RSP_ACK,
   input wire logic [15:0]        RSP_DATA,
   input wire logic               RSP_READY,
   input wire logic               EE_REQ,
   input wire ebp_pkg::ebp_eeop_t EE_OP,
   input wire logic [15:0]        EE_ADDR,
   input wire logic               EE_ACK,
   input wire logic [15:0]        EE_RDATA,
   input wire logic               BUSY_N
);
   logic take;
   assign take = CE && CMD_VALID && CMD_READY;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // a lone take into an empty answer path, so the answer lands exactly two edges on
   sequence s_busy_take;
      !take ##1 (take && !RSP_VALID && !BUSY_N && CMD_CODE != CMD_COMMON_STATUS);
   endsequence
   sequence s_status_take;
      !take ##1 (take && !RSP_VALID && CMD_CODE == CMD_COMMON_STATUS && !CMD_WRITE);
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !ARST_N |->
      !CMD_READY && !RSP_VALID && !EE_REQ && BUSY_N) else $error("outputs not idle in reset");
   a_busy_flag: assert property (EE_REQ |-> !BUSY_N)
      else $error("not-busy flag high during eeprom access");
   a_req_holds: assert property (EE_REQ && !EE_ACK |=>
      EE_REQ && $stable(EE_OP) && $stable(EE_ADDR)) else $error("eeprom request changed");
   a_req_ends: assert property (EE_REQ && EE_ACK && CE |=> !EE_REQ && BUSY_N)
      else $error("busy did not end after eeprom ack");
   a_read_blocks: assert property (EE_REQ && EE_OP == EE_READ |-> !CMD_READY)
      else $error("command taken during eeprom read");
   a_rsp_holds: assert property (RSP_VALID && !RSP_READY |=>
      RSP_VALID && $stable(RSP_DATA) && $stable(RSP_ACK)) else $error("answer changed in stall");
   a_read_data: assert property (EE_REQ && EE_ACK && EE_OP == EE_READ && !RSP_VALID |=>
      ##1 (RSP_VALID && RSP_DATA == $past(EE_RDATA, 2))) else $error("read word not passed on");
   a_busy_nack: assert property (s_busy_take |=> ##1 (RSP_VALID && !RSP_ACK))
      else $error("command not refused while busy");
   a_status_ok: assert property (s_status_take |=> ##1
      (RSP_VALID && RSP_ACK && RSP_DATA[15:7] == '0 && RSP_DATA[5:0] == '0))
      else $error("status read refused or malformed");
endmodule
bind ebp_bulk_access ebp_bulk_properties u_props (.REF_CLK, .ARST_N, .CE, .CMD_VALID,
   .CMD_CODE, .CMD_WRITE, .CMD_READY, .RSP_VALID, .RSP_ACK, .RSP_DATA, .RSP_READY,
   .EE_REQ, .EE_OP, .EE_ADDR, .EE_ACK, .EE_RDATA, .BUSY_N);
`default_nettype wire

// [sim/ebp_ee_model.sv]
// eeprom controller model: user plus mfr words, one-cycle ack after a delay
// assumes the request level is held until ack; erase is four times slower
`timescale 1ns/1ps
`default_nettype none
module ebp_ee_model
   import ebp_pkg::*;
#(
   parameter int DLY = 6
)
(
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               req,
   input  wire ebp_pkg::ebp_eeop_t op,
   input  wire logic [15:0]        addr,
   input  wire logic [15:0]        wdata,
   output logic                    ack,
   output logic [15:0]             rdata
);
   logic [15:0] mem [576];
   int          cnt;
   logic        hold;
   initial begin
      for (int i = 0; i < 576; i++) mem[i] = 16'(i) ^ 16'hA5A5;
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack <= 1'b0;
         cnt <= 0;
         hold <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         ack <= 1'b0;
         // data toggles outside the ack cycle so a late sample cannot pass
         rdata <= ~rdata;
         if (!req) begin
            hold <= 1'b0;
            cnt <= 0;
         end else if (!hold) begin
            cnt <= cnt + 1;
            if (cnt >= (op == EE_ERASE ? 4 * DLY : DLY)) begin
               ack <= 1'b1;
               hold <= 1'b1;
               if (op == EE_READ) rdata <= mem[addr[9:0]];
               if (op == EE_WRITE) mem[addr[9:0]] <= wdata;
               if (op == EE_ERASE) for (int i = 0; i < 512; i++) mem[i] <= 16'hFFFF;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench: decoded pmbus commands in, answers and eeprom model out
// assumes the package codes and the model's preset pattern addr ^ a5a5
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
   import ebp_pkg::*;
   localparam logic [7:0] UK = CMD_UNLOCK_KEY, ER = CMD_ERASE_TRIGGER;
   localparam logic [7:0] WP = CMD_WORD_PORT, ST = CMD_COMMON_STATUS;
   logic REF_CLK = 0, ARST_N = 1, CE = 1, CMD_VALID = 0, CMD_WRITE = 0, CMD_PEC = 1;
   logic RSP_READY = 1, CMD_READY, RSP_VALID, RSP_ACK, EE_REQ, EE_ACK, BUSY_N, PEC_REQUIRED;
   logic [7:0] CMD_CODE = 8'h00;
   logic [15:0] CMD_WDATA = 16'h0000, RSP_DATA, EE_ADDR, EE_WDATA, EE_RDATA;
   ebp_eeop_t EE_OP;
   int bad_count = 0, n_checks = 0, cycles = 0, takes, got;
   logic [7:0] keys [4] = '{KEY_RW_PEC_OPT, KEY_RW_PEC_REQ, KEY_RO_PEC_OPT, KEY_RO_PEC_REQ};
   ebp_bulk_access dut (.REF_CLK, .ARST_N, .CE, .CMD_VALID, .CMD_CODE, .CMD_WRITE, .CMD_PEC,
      .CMD_WDATA, .CMD_READY, .RSP_VALID, .RSP_ACK, .RSP_DATA, .RSP_READY, .EE_REQ, .EE_OP,
      .EE_ADDR, .EE_WDATA, .EE_ACK, .EE_RDATA, .BUSY_N, .PEC_REQUIRED);
   ebp_ee_model #(.DLY(6)) u_ee (.clk(REF_CLK), .arst_n(ARST_N), .req(EE_REQ), .op(EE_OP),
      .addr(EE_ADDR), .wdata(EE_WDATA), .ack(EE_ACK), .rdata(EE_RDATA));
   initial begin
      forever #10 REF_CLK = ~REF_CLK;
   end
   task automatic tally_and_finish;
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // ready is a flop, so its value at the falling edge is what the next edge samples
   task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d,
                       output logic a, output logic [15:0] r);
      int n;
      @(negedge REF_CLK);
      CMD_VALID = 1'b1;
      CMD_CODE = c;
      CMD_WRITE = w;
      CMD_WDATA = d;
      for (n = 0; CMD_READY !== 1'b1 && n < 50; n++) @(negedge REF_CLK);
      @(negedge REF_CLK);
      CMD_VALID = 1'b0;
      for (n = 0; RSP_VALID !== 1'b1 && n < 100; n++) @(negedge REF_CLK);
      a = RSP_ACK;
      r = RSP_DATA;
   endtask
   task automatic op(input logic [7:0] c, input logic w, input logic [15:0] d,
                     input logic ea, input logic [15:0] ed);
      logic a;
      logic [15:0] r;
      xfer(c, w, d, a, r);
      `CHK(a, ea)
      if (!w && ea) `CHK(r, ed)
   endtask
   task automatic wait_idle;
      logic a;
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 100 && r[NOT_BUSY_BIT] !== 1'b1; i++) xfer(ST, 1'b0, 16'h0000, a, r);
   endtask
   task automatic unlock(input int m);
      op(UK, 1'b1, 16'h002B, 1'b1, 16'h0000);
      if (m > 1) op(UK, 1'b1, 16'h0091, 1'b1, 16'h0000);
      op(UK, 1'b1, {8'h00, keys[m]}, 1'b1, 16'h0000);
   endtask
   task automatic erase_ok;
      op(ER, 1'b1, 16'h002B, 1'b1, 16'h0000);
      op(ST, 1'b0, 16'h0000, 1'b1, 16'h0000);
      op(UK, 1'b0, 16'h0000, 1'b0, 16'h0000);
      wait_idle();
   endtask
   initial begin
      // a real falling edge on reset, so the flops are defined before the first clock
      #1 ARST_N = 1'b0;
      repeat (12) @(posedge REF_CLK);
      @(negedge REF_CLK);
      ARST_N = 1'b1;
      `CHK(BUSY_N, 1'b1)
      op(UK, 1'b0, 16'h0000, 1'b1, 16'h0000);
      op(WP, 1'b0, 16'h0000, 1'b0, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         unlock(m);
         `CHK(PEC_REQUIRED, logic'(m[0]))
         op(UK, 1'b0, 16'h0000, 1'b1, {8'h00, keys[m]});
         op(WP, 1'b0, 16'h0000, 1'b1, PACKING_REVISION);
         op(WP, 1'b0, 16'h0000, 1'b1,
            m < 2 ? USER_WORD_COUNT : 16'(USER_WORD_COUNT + MFR_WORD_COUNT));
         op(WP, 1'b0, 16'h0000, 1'b1, 16'hA5A5);
         op(WP, 1'b0, 16'h0000, 1'b1, 16'hA5A4);
      end
      CMD_PEC = 1'b0;
      op(WP, 1'b0, 16'h0000, 1'b0, 16'h0000);
      CMD_PEC = 1'b1;
      unlock(0);
      op(UK, 1'b1, 16'h0077, 1'b1, 16'h0000);
      op(UK, 1'b0, 16'h0000, 1'b1, 16'h0000);
      op(WP, 1'b0, 16'h0000, 1'b0, 16'h0000);
      unlock(0);
      op(ER, 1'b1, 16'h0055, 1'b1, 16'h0000);
      op(ER, 1'b0, 16'h0000, 1'b1, 16'h0055);
      op(UK, 1'b0, 16'h0000, 1'b1, 16'h0000);
      unlock(1);
      erase_ok();
      op(WP, 1'b1, 16'h1234, 1'b1, 16'h0000);
      wait_idle();
      op(WP, 1'b0, 16'h0000, 1'b0, 16'h0000);
      unlock(1);
      erase_ok();
      `CHK(u_ee.mem[0], 16'hFFFF)
      `CHK(u_ee.mem[512], 16'h0200 ^ 16'hA5A5)
      for (int i = 0; i < 512; i++) begin
         op(WP, 1'b1, 16'(i) ^ 16'h3C3C, 1'b1, 16'h0000);
         wait_idle();
      end
      op(WP, 1'b1, 16'h0000, 1'b1, 16'h0000);
      op(UK, 1'b0, 16'h0000, 1'b1, 16'h0000);
      `CHK(u_ee.mem[511], 16'h01FF ^ 16'h3C3C)
      unlock(0);
      op(WP, 1'b0, 16'h0000, 1'b1, PACKING_REVISION);
      op(WP, 1'b0, 16'h0000, 1'b1, USER_WORD_COUNT);
      for (int i = 0; i < 512; i++) op(WP, 1'b0, 16'h0000, 1'b1, 16'(i) ^ 16'h3C3C);
      op(WP, 1'b0, 16'h0000, 1'b1, 16'h0000);
      op(UK, 1'b0, 16'h0000, 1'b1, 16'h0000);
      // stalled host: the buffer must refuse once full and lose nothing
      @(negedge REF_CLK);
      RSP_READY = 1'b0;
      CMD_VALID = 1'b1;
      CMD_CODE = ER;
      CMD_WRITE = 1'b0;
      takes = 0;
      got = 0;
      repeat (10) begin
         if (CMD_READY === 1'b1) takes++;
         @(negedge REF_CLK);
      end
      CMD_VALID = 1'b0;
      RSP_READY = 1'b1;
      repeat (10) begin
         if (RSP_VALID === 1'b1) got++;
         @(negedge REF_CLK);
      end
      `CHK(takes < 10, 1'b1)
      `CHK(got, takes)
      tally_and_finish();
   end
endmodule
`default_nettype wire
